// [srap_pkg.sv]
// Shared constants of the serial register access port.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package srap_pkg;
  // Frame layout, most significant bit first
  localparam int unsigned     FRAME_BITS_N = 17;
  localparam logic [4:0]      FRAME_BITS   = 5'h11;
  localparam logic [4:0]      CNT_MAX      = 5'h1f;
  localparam int unsigned     RW_POS       = 16;
  localparam int unsigned     ADDR_MSB     = 15;
  localparam int unsigned     ADDR_LSB     = 8;
  localparam int unsigned     DATA_MSB     = 7;
  localparam logic            RW_READ      = 1'h1;

  // Page select register
  localparam logic [7:0]      PAGE_ADDR    = 8'hff;
  localparam logic [7:0]      PAGE_RESET   = 8'h00;
  localparam logic [2:0]      PAGE_GLOBAL  = 3'h0;
  localparam logic [2:0]      PAGE_EQ      = 3'h4;
  localparam logic [2:0]      PAGE_DRIVER  = 3'h5;

  // Interface select strap levels
  localparam logic [1:0]      STRAP_LOW    = 2'h0;
  localparam logic [1:0]      STRAP_RES    = 2'h1;
  localparam logic [1:0]      STRAP_FLOAT  = 2'h2;
  localparam logic [1:0]      STRAP_HIGH   = 2'h3;

  // Bit positions of the synchronised pin vector
  localparam int unsigned     PIN_MOSI     = 0;
  localparam int unsigned     PIN_SEL      = 1;
  localparam int unsigned     PIN_SCK      = 2;
  localparam int unsigned     PIN_N        = 3;

  typedef enum logic [0:0] {
    SRAP_IDLE = 1'b0,
    SRAP_LOAD = 1'b1
  } srap_state_e;
endpackage
`default_nettype wire

// [srap_pin_if.sv]
// Bundle between the pin synchroniser and the port core.
// Assumes raw pins are asynchronous to core_clk.
`default_nettype none
interface srap_pin_if #(parameter int unsigned W = 3);
  logic [W-1:0] raw;
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport sync (input raw, output lvl, output rise, output fall);
  modport core (output raw, input lvl, input rise, input fall);
endinterface
`default_nettype wire

// [srap_sync.sv]
// Three-flop pin synchroniser with agreement filter and edge pulses.
// Assumes one clock; raw inputs may change at any time.
`default_nettype none
module srap_sync #(
  parameter int unsigned W = 3
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Pins in, clean levels out
  srap_pin_if.sync  pin
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } srap_sync_s;

  srap_sync_s q;
  srap_sync_s d;

  if (W == 0) begin : g_chk
    $error("srap_sync needs at least one pin");
  end

  always_comb begin
    d     = q;
    d.s1  = pin.raw;
    d.s2  = q.s1;
    d.s3  = q.s2;
    // A change counts once the second and third stages agree
    d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 | q.s3));
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign pin.lvl  = q.lvl;
  assign pin.rise = d.lvl & ~q.lvl;
  assign pin.fall = ~d.lvl & q.lvl;
endmodule
`default_nettype wire

// [srap_port.sv]
// Serial register access port: 17-bit frame shift register, page select.
// Assumes the register file outside answers reg_rdata combinationally.
// Operation
// - Serial port serves registers only when strap is float or high.
// - A frame is 17 bits shifted while frame select is low.
// - With select high, MOSI is ignored and MISO is not driven.
// - Order: read/write flag, eight address bits, eight data bits.
// - MISO shifts out the previous frame as the new one shifts in.
// - MISO driver turns on asynchronously when select falls.
// - Write frames commit on the rising edge of frame select.
// - MOSI bits are captured on rising serial clock edges.
// - First read frame data bits are ignored by the device.
// - Dummy second frame acts as a read of address register_page_select.
// - Second read frame returns address then eight data bits.
// - A chain of N devices needs 17 times N clocks per frame.
// - Bits 2:0 of register register_page_select select page; global after reset.
// - Page 4 is equalizer and routing, page 5 driver settings.
`default_nettype none
module srap_port (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Interface select strap level
  input  wire logic [1:0] mode_strap,
  // Serial pins
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  output logic            miso,
  output logic            miso_oe,
  // Register file access
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr_en,
  input  wire logic [7:0] reg_rdata,
  // Status
  output logic            spi_mode,
  output logic [2:0]      page_sel
);
  typedef struct packed {
    logic                 strap_done;
    logic                 spi_en;
    srap_pkg::srap_state_e state;
    logic [16:0]          sr;
    logic [4:0]           cnt;
    logic                 miso;
    logic [7:0]           addr;
    logic [7:0]           wdata;
    logic                 wr;
    logic [7:0]           page;
  } srap_port_s;

  srap_port_s q;
  srap_port_s d;
  logic       frame_end;
  logic       active;

  srap_pin_if #(.W(srap_pkg::PIN_N)) pin_if ();

  assign pin_if.raw = {sck, ss_n, mosi};

  srap_sync #(.W(srap_pkg::PIN_N)) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pin      (pin_if.sync)
  );

  assign active    = q.spi_en & ~pin_if.lvl[srap_pkg::PIN_SEL];
  // Select rise after 17 bits closes frame
  assign frame_end = q.spi_en & pin_if.rise[srap_pkg::PIN_SEL]
                   & (q.cnt >= srap_pkg::FRAME_BITS);

  always_comb begin
    d    = q;
    d.wr = 1'b0;
    if (!q.strap_done) begin
      d.strap_done = 1'b1;
      d.spi_en     = (mode_strap == srap_pkg::STRAP_FLOAT)
                   | (mode_strap == srap_pkg::STRAP_HIGH);
    end
    // Data field loaded for the next frame
    unique case (q.state)
      srap_pkg::SRAP_IDLE: begin
        d.state = srap_pkg::SRAP_IDLE;
      end
      srap_pkg::SRAP_LOAD: begin
        // Address register_page_select reads back page value
        d.sr[srap_pkg::DATA_MSB:0] = (q.addr == srap_pkg::PAGE_ADDR) ? q.page : reg_rdata;
        d.state                    = srap_pkg::SRAP_IDLE;
      end
    endcase
    if (q.spi_en && pin_if.fall[srap_pkg::PIN_SEL]) begin
      // First old bit presented at frame start
      d.miso = q.sr[srap_pkg::RW_POS];
      d.cnt  = '0;
    end
    if (active && pin_if.rise[srap_pkg::PIN_SCK]) begin
      d.sr = {q.sr[srap_pkg::RW_POS-1:0], pin_if.lvl[srap_pkg::PIN_MOSI]};
      // Count saturates, last 17 bits win
      if (q.cnt != srap_pkg::CNT_MAX) begin
        d.cnt = q.cnt + 5'h1;
      end
    end
    // Next bit out on falling clock
    if (active && pin_if.fall[srap_pkg::PIN_SCK]) begin
      d.miso = q.sr[srap_pkg::RW_POS];
    end
    // Decode flag, address and data of the last 17 bits
    if (frame_end) begin
      d.addr  = q.sr[srap_pkg::ADDR_MSB:srap_pkg::ADDR_LSB];
      d.wdata = q.sr[srap_pkg::DATA_MSB:0];
      if (q.sr[srap_pkg::RW_POS] == srap_pkg::RW_READ) begin
        // Incoming data bits of a read dropped
        d.state = srap_pkg::SRAP_LOAD;
      end else if (q.sr[srap_pkg::ADDR_MSB:srap_pkg::ADDR_LSB] == srap_pkg::PAGE_ADDR) begin
        d.page = q.sr[srap_pkg::DATA_MSB:0];
      end else begin
        d.wr = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      q            <= '0;
      q.state      <= srap_pkg::SRAP_IDLE;
      q.page       <= srap_pkg::PAGE_RESET;
    end else begin
      q <= d;
    end
  end

  assign miso      = q.miso;
  assign miso_oe   = q.spi_en & ~ss_n;
  assign reg_addr  = q.addr;
  assign reg_wdata = q.wdata;
  assign reg_wr_en = q.wr;
  assign spi_mode  = q.spi_en;
  assign page_sel  = q.page[2:0];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_oe_off_idle: assert property (ss_n |-> !miso_oe)
    else $error("MISO driven while select high");
  a_oe_needs_mode: assert property (!spi_mode |-> !miso_oe)
    else $error("MISO driven outside serial mode");
  a_write_commit: assert property (
    frame_end && !q.sr[16] && q.sr[15:8] != srap_pkg::PAGE_ADDR
    |=> reg_wr_en && reg_addr == $past(q.sr[15:8]) && reg_wdata == $past(q.sr[7:0]))
    else $error("Write frame not committed");
  a_wr_one_cycle: assert property (reg_wr_en |=> !reg_wr_en)
    else $error("Write strobe longer than one cycle");
  a_shift_capture: assert property (
    active && pin_if.rise[srap_pkg::PIN_SCK] |=> q.sr[0] == $past(pin_if.lvl[0])
      && q.sr[16:1] == $past(q.sr[15:0]))
    else $error("MOSI bit not captured");
  a_miso_on_fall: assert property (
    active && pin_if.fall[srap_pkg::PIN_SCK] |=> miso == $past(q.sr[16]))
    else $error("MISO not updated on falling clock");
  a_page_write: assert property (
    frame_end && !q.sr[16] && q.sr[15:8] == srap_pkg::PAGE_ADDR
    |=> page_sel == $past(q.sr[2:0]) && !reg_wr_en)
    else $error("Page select not written");
  a_page_reset: assert property (!q.strap_done |-> page_sel == srap_pkg::PAGE_GLOBAL)
    else $error("Page not global after reset");
  a_read_load: assert property (
    frame_end && q.sr[16] |=> ##1 q.sr[7:0] == ($past(reg_addr) == srap_pkg::PAGE_ADDR
      ? $past(q.page) : $past(reg_rdata)) && q.sr[16:8] == $past(q.sr[16:8], 2))
    else $error("Read data not loaded");
  a_short_drop: assert property (
    q.spi_en && pin_if.rise[srap_pkg::PIN_SEL] && q.cnt < srap_pkg::FRAME_BITS
    |=> !reg_wr_en && $stable(page_sel))
    else $error("Short frame executed");
  a_frame_start: assert property (
    q.spi_en && pin_if.fall[srap_pkg::PIN_SEL] |=> miso == $past(q.sr[srap_pkg::RW_POS]))
    else $error("Old flag bit not presented at frame start");
  a_idle_ignore: assert property (
    !active && q.state == srap_pkg::SRAP_IDLE |=> $stable(q.sr[16:1]))
    else $error("Shift register moved outside a frame");

  c_write_frame: cover property (frame_end && !q.sr[16]);
  c_read_frame: cover property (frame_end && q.sr[16] ##[1:1000] frame_end);
  c_page_eq: cover property (page_sel == srap_pkg::PAGE_EQ);
  c_chain_two: cover property (frame_end && q.cnt == 5'h1_f);
endmodule
`default_nettype wire

// [srap_host_model.sv]
// Host serial master model: frames, bit order and two-frame reads.
// Assumes core_clk at 8 ns; link clock is high for 10 core cycles (80 ns) and low for 11.
`default_nettype none
module srap_host_model (
  // Clock
  input  wire logic core_clk,
  // Serial pins
  output var logic  sck,
  output var logic  ss_n,
  output var logic  mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sck  = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end

  task automatic shift_n(input int n, input logic [33:0] tx, output logic [33:0] rx);
    rx = '0;
    @(posedge core_clk) ss_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge core_clk) mosi <= tx[i];
      repeat (10) @(posedge core_clk);
      rx[i] = miso;
      sck <= 1'b1;
      repeat (10) @(posedge core_clk);
      sck <= 1'b0;
    end
    repeat (10) @(posedge core_clk);
    ss_n <= 1'b1;
    mosi <= ~tx[0];
    repeat (12) @(posedge core_clk);
  endtask

  task automatic xfer(input logic [16:0] tx, output logic [16:0] rx);
    logic [33:0] wide;
    shift_n(17, {17'h0_0000, tx}, wide);
    rx = wide[16:0];
  endtask

  // command frame, then dummy read of register_page_select
  task automatic rd(input logic [7:0] a, output logic [16:0] rx);
    logic [16:0] unused;
    xfer({1'b1, a, 8'hff}, unused);
    xfer({1'b1, 8'hff, 8'hff}, rx);
  endtask
endmodule
`default_nettype wire

// [test_spi_register_access_port.sv]
// Testbench of the serial register access port with a host model.
// Assumes srap_pkg, srap_pin_if, srap_sync and srap_port compiled first.
`default_nettype none
module test_spi_register_access_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk;
  logic        reset_n;
  logic [1:0]  mode_strap;
  wire logic   sck;
  wire logic   ss_n;
  wire logic   mosi;
  wire logic   miso_ln;
  logic        miso;
  logic        miso_oe;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr_en;
  logic        spi_mode;
  logic [2:0]  page_sel;
  logic [7:0]  mem [256];
  logic [16:0] rx;
  logic [33:0] rx2;
  logic [2:0]  pg [3];
  int          err_total;
  int          checks_done;

  // Released line shows the inverse, not a held value
  assign miso_ln = miso_oe ? miso : ~miso;

  srap_port dut (.core_clk(core_clk), .reset_n(reset_n), .mode_strap(mode_strap),
    .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en),
    .reg_rdata(mem[reg_addr]), .spi_mode(spi_mode), .page_sel(page_sel));

  srap_host_model host (.core_clk(core_clk), .sck(sck), .ss_n(ss_n), .mosi(mosi),
    .miso(miso_ln));

  // Register file beside the port
  always @(posedge core_clk) begin
    if (reg_wr_en) mem[reg_addr] <= reg_wdata;
  end

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("mismatches %0d of %0d checks", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    err_total = 0;
    checks_done = 0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3c;
    pg = '{srap_pkg::PAGE_EQ, srap_pkg::PAGE_DRIVER, srap_pkg::PAGE_GLOBAL};
    reset_n = 1'b0;
    mode_strap = srap_pkg::STRAP_FLOAT;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(17'(spi_mode), 17'h1_0001 & 17'h0_0001);
    chk(17'(page_sel), 17'h0_0000);
    chk(17'(miso_oe), 17'h0_0000);
    fork
      host.xfer({1'b0, 8'h12, 8'ha5}, rx);
      begin
        repeat (2) @(posedge core_clk);
        chk(17'(miso_oe), 17'h0_0001);
      end
    join
    chk(17'(mem[8'h12]), 17'h0_00a5);
    host.xfer({1'b0, 8'h34, 8'h5a}, rx);
    chk(rx, {1'b0, 8'h12, 8'ha5});
    host.rd(8'h12, rx);
    chk(rx, {1'b1, 8'h12, 8'ha5});
    for (int i = 0; i < 3; i++) begin
      host.xfer({1'b0, srap_pkg::PAGE_ADDR, 5'h00, pg[i]}, rx);
      chk(17'(page_sel), 17'(pg[i]));
    end
    host.xfer({1'b0, srap_pkg::PAGE_ADDR, 8'h05}, rx);
    host.rd(srap_pkg::PAGE_ADDR, rx);
    chk(rx, {1'b1, 8'hff, 8'h05});
    chk(17'(mem[8'hff]), 17'h0_00c3);
    host.shift_n(34, {1'b0, 8'h56, 8'h77, 1'b0, 8'h66, 8'hc9}, rx2);
    chk(rx2[33:17], {1'b1, 8'hff, 8'h05});
    chk(rx2[16:0], {1'b0, 8'h56, 8'h77});
    chk(17'(mem[8'h66]), 17'h0_00c9);
    chk(17'(mem[8'h56]), 17'h0_006a);
    reset_n <= 1'b0;
    mode_strap <= srap_pkg::STRAP_LOW;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(17'(spi_mode), 17'h0_0000);
    chk(17'(page_sel), 17'h0_0000);
    fork
      host.xfer({1'b0, 8'h12, 8'h00}, rx);
      begin
        repeat (2) @(posedge core_clk);
        chk(17'(miso_oe), 17'h0_0000);
      end
    join
    chk(17'(mem[8'h12]), 17'h0_00a5);
    conclude();
  end
endmodule
`default_nettype wire
